// ===== core/gpib_tape_pkg.sv
package gpib_tape_pkg;
   // Bus byte groups seen on data bits 6:5 while ATN is asserted
   localparam logic [1:0] GRP_LISTEN = 2'h1;
   localparam logic [1:0] GRP_TALK = 2'h2;
   localparam logic [1:0] GRP_SECOND = 2'h3;
   localparam logic [4:0] ADDR_NONE = 5'h1f; // Unlisten / untalk address field

   // Secondary addresses, listen side
   localparam logic [4:0] SA_SETSTAT = 5'h00;
   localparam logic [4:0] SA_SAVE = 5'h01;
   localparam logic [4:0] SA_CLOSE = 5'h02;
   localparam logic [4:0] SA_KILL = 5'h07;
   localparam logic [4:0] SA_PRINT = 5'h0c;
   localparam logic [4:0] SA_WRITE = 5'h0f;
   localparam logic [4:0] SA_LISTEN = 5'h19;
   localparam logic [4:0] SA_FIND = 5'h1b;
   localparam logic [4:0] SA_MARK = 5'h1c;
   localparam logic [4:0] SA_SECRET = 5'h1d;
   // Secondary addresses, talk side
   localparam logic [4:0] SA_STATQ = 5'h00;
   localparam logic [4:0] SA_APPEND = 5'h04;
   localparam logic [4:0] SA_TYPEQ = 5'h06;
   localparam logic [4:0] SA_HEADER = 5'h09;
   localparam logic [4:0] SA_INPUT = 5'h0d;
   localparam logic [4:0] SA_READ = 5'h0e;
   localparam logic [4:0] SA_RDERRQ = 5'h18;
   localparam logic [4:0] SA_TALK = 5'h1a;
   localparam logic [4:0] SA_ERRQ = 5'h1e;

   // Characters
   localparam logic [7:0] CHAR_CR = 8'h0d;
   localparam logic [7:0] CHAR_COMMA = 8'h2c;
   localparam logic [7:0] CHAR_SEMI = 8'h3b;
   localparam logic [7:0] CHAR_ZERO = 8'h30;
   localparam logic [7:0] CHAR_NINE = 8'h39;
   localparam logic [7:0] ERR_INVALID = 8'h01; // Code reported for a refused command

   typedef enum logic [4:0] {
      OP_NONE = 5'h00, OP_CLOSE = 5'h01, OP_FIND = 5'h02, OP_KILL = 5'h03,
      OP_MARK = 5'h04, OP_SECRET = 5'h05, OP_SETSTAT = 5'h06, OP_SAVE = 5'h07,
      OP_PRINT = 5'h08, OP_WRITE = 5'h09, OP_LISTEN = 5'h0a, OP_APPEND = 5'h0b,
      OP_HEADER = 5'h0c, OP_INPUT = 5'h0d, OP_READ = 5'h0e, OP_TALK = 5'h0f,
      OP_ERRQ = 5'h10, OP_RDERRQ = 5'h11, OP_STATQ = 5'h12, OP_TYPEQ = 5'h13
   } op_e;

   // Command handed to the tape engine
   typedef struct packed {
      op_e op;
      logic [15:0] arg0;
      logic [15:0] arg1;
   } cmd_s;

   // Byte presented to the bus as talker
   typedef struct packed {
      logic [7:0] data;
      logic eoi;
   } talk_s;
endpackage : gpib_tape_pkg

// ===== core/gpib_tape_command_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module gpib_tape_command_decoder
   import gpib_tape_pkg::*;
(
   input wire logic ref_clk, // 200 MHz clock
   input wire logic arst_n, // Asynchronous reset
   input wire logic byteValid, // One bus byte accepted this cycle
   input wire logic [7:0] byteData, // Bus data byte
   input wire logic atnIn, // ATN level
   input wire logic eoiIn, // EOI with the byte
   input wire logic [4:0] addrSwitch, // Address switches
   input wire logic altMode, // Alternate protocol selected
   input wire logic txAccept, // Bus took the talk byte
   input wire logic srcValid, // Engine stream byte present
   input wire logic [7:0] srcData, // Engine stream byte
   input wire logic srcLast, // Engine stream last byte
   input wire logic [3:0] errCode, // Engine error code
   input wire logic engErr, // Engine error event pulse
   input wire logic [7:0] rereadCount, // Engine re-read count
   input wire logic [2:0] typeDigit, // Next item kind
   output cmd_s cmd, // Command to engine
   output logic cmdValid, // Command strobe
   output logic wrValid, // Record byte strobe
   output logic [7:0] wrData, // Record byte
   output logic wrLast, // Record byte carried EOI in a write session
   output logic dataEnd, // Recording closed by unlisten
   output logic srcTake, // Engine byte consumed
   output talk_s tx, // Talk byte
   output logic txValid, // Talk byte valid
   output logic rereadClr, // Clear engine re-read count
   output logic errFlag, // Error condition pending
   output logic [3:0] statusBits, // Option status parameters
   output logic talkActive, // Addressed as talker
   output logic listenActive // Addressed as listener
);
   logic listenEn_r, talkEn_r, cmdListen_r, lastAddrd_r, lastTalk_r;
   logic started_r, letterSeen_r, recording_r, streaming_r, fldDig_r;
   op_e selOp_r, pendOp_r, letOp_r;
   logic [15:0] fld_r [0:3];
   logic [1:0] fldIdx_r;
   logic [7:0] qBuf_r [0:7];
   logic [3:0] qLen_r, qIdx_r;
   logic [4:0] dataPrimaryAddress, commandPrimaryAddress, addr;
   logic isListen, isTalk, isSecond, ourListen, ourTalk, dataByte;
   logic crSeen, digitSeen, sepSeen, argFinish, talkStart, listenStart;
   logic txFree, errSet, errClr;
   op_e argOp, secOp;
   logic [7:0] qImg [0:7];
   logic [3:0] qLen;
   logic [7:0] qVal;

   function automatic op_e sa_to_op(input logic [4:0] sa, input logic talk);
      op_e o;
      o = OP_NONE;
      if (talk) begin
         unique case (sa)
            SA_STATQ: o = OP_STATQ;
            SA_APPEND: o = OP_APPEND;
            SA_TYPEQ: o = OP_TYPEQ;
            SA_HEADER: o = OP_HEADER;
            SA_INPUT: o = OP_INPUT;
            SA_READ: o = OP_READ;
            SA_RDERRQ: o = OP_RDERRQ;
            SA_TALK: o = OP_TALK;
            SA_ERRQ: o = OP_ERRQ;
            default: o = OP_NONE;
         endcase
      end else begin
         unique case (sa)
            SA_SETSTAT: o = OP_SETSTAT;
            SA_SAVE: o = OP_SAVE;
            SA_CLOSE: o = OP_CLOSE;
            SA_KILL: o = OP_KILL;
            SA_PRINT: o = OP_PRINT;
            SA_WRITE: o = OP_WRITE;
            SA_LISTEN: o = OP_LISTEN;
            SA_FIND: o = OP_FIND;
            SA_MARK: o = OP_MARK;
            SA_SECRET: o = OP_SECRET;
            default: o = OP_NONE;
         endcase
      end
      return o;
   endfunction : sa_to_op

   function automatic op_e letter_to_op(input logic [7:0] c);
      op_e o;
      unique case (c)
         8'h43: o = OP_CLOSE;
         8'h45: o = OP_ERRQ;
         8'h46: o = OP_FIND;
         8'h48: o = OP_HEADER;
         8'h49: o = OP_INPUT;
         8'h4b: o = OP_KILL;
         8'h4c: o = OP_LISTEN;
         8'h4d: o = OP_MARK;
         8'h4f: o = OP_APPEND;
         8'h50: o = OP_PRINT;
         8'h51: o = OP_SETSTAT;
         8'h52: o = OP_READ;
         8'h53: o = OP_SAVE;
         8'h54: o = OP_TYPEQ;
         8'h57: o = OP_WRITE;
         8'h58: o = OP_SECRET;
         8'h59: o = OP_STATQ;
         8'h5a: o = OP_TALK;
         default: o = OP_NONE;
      endcase
      return o;
   endfunction : letter_to_op

   function automatic logic is_arg(input op_e o);
      return o inside {OP_CLOSE, OP_FIND, OP_KILL, OP_MARK, OP_SECRET, OP_SETSTAT};
   endfunction : is_arg

   function automatic logic is_rec(input op_e o);
      return o inside {OP_SAVE, OP_PRINT, OP_WRITE, OP_LISTEN};
   endfunction : is_rec

   function automatic logic is_query(input op_e o);
      return o inside {OP_ERRQ, OP_RDERRQ, OP_STATQ, OP_TYPEQ};
   endfunction : is_query

   // Address decode; alternate mode pairs an even data and odd command address
   assign dataPrimaryAddress = {addrSwitch[4:1], 1'b0};
   assign commandPrimaryAddress = {addrSwitch[4:1], 1'b1};
   assign addr = byteData[4:0];
   assign isListen = byteValid && atnIn && byteData[6:5] == GRP_LISTEN;
   assign isTalk = byteValid && atnIn && byteData[6:5] == GRP_TALK;
   assign isSecond = byteValid && atnIn && byteData[6:5] == GRP_SECOND;
   assign ourListen = addr != ADDR_NONE && (altMode ?
      (addr == dataPrimaryAddress || addr == commandPrimaryAddress) : addr == addrSwitch);
   assign ourTalk = ourListen;
   assign dataByte = byteValid && !atnIn && listenEn_r;
   assign crSeen = byteData == CHAR_CR;
   assign digitSeen = byteData >= CHAR_ZERO && byteData <= CHAR_NINE;
   assign sepSeen = byteData == CHAR_COMMA || byteData == CHAR_SEMI;
   // Secondary bytes only count straight after our own primary in the base protocol
   assign secOp = sa_to_op(addr, lastTalk_r);
   // Argument commands end on CR; the letter channel decides at the same point
   assign argOp = cmdListen_r ? letOp_r : selOp_r;
   assign argFinish = dataByte && crSeen && (cmdListen_r ? letterSeen_r : is_arg(selOp_r));
   assign talkStart = talkEn_r && !atnIn && !started_r;
   assign listenStart = listenEn_r && !atnIn && !started_r && !cmdListen_r;
   assign txFree = !txValid || txAccept;
   assign errSet = engErr || (isSecond && !altMode && lastAddrd_r && secOp == OP_NONE)
      || (dataByte && cmdListen_r && !letterSeen_r && letter_to_op(byteData) == OP_NONE);
   assign errClr = talkStart && selOp_r == OP_ERRQ; // Reading the code clears it

   // Query answer image, built from live values when the talk phase opens
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         qImg[i] = CHAR_CR;
      end
      qVal = errCode != 4'h0 ? {4'h0, errCode} : (errFlag ? ERR_INVALID : 8'h00);
      if (selOp_r == OP_RDERRQ) begin
         qVal = rereadCount;
      end
      qLen = 4'h2;
      unique case (selOp_r)
         OP_STATQ: begin
            for (int i = 0; i < 4; i++) begin
               qImg[2 * i] = CHAR_ZERO | {7'h00, statusBits[i]};
               if (i < 3) begin
                  qImg[2 * i + 1] = CHAR_COMMA;
               end
            end
            qLen = 4'h8;
         end
         OP_TYPEQ: qImg[0] = CHAR_ZERO | {5'h00, typeDigit};
         default: begin
            if (qVal >= 8'd100) begin
               qImg[0] = CHAR_ZERO + 8'(qVal / 8'd100);
               qImg[1] = CHAR_ZERO + 8'((qVal / 8'd10) % 8'd10);
               qImg[2] = CHAR_ZERO + 8'(qVal % 8'd10);
               qLen = 4'h4;
            end else if (qVal >= 8'd10) begin
               qImg[0] = CHAR_ZERO + 8'(qVal / 8'd10);
               qImg[1] = CHAR_ZERO + 8'(qVal % 8'd10);
               qLen = 4'h3;
            end else begin
               qImg[0] = CHAR_ZERO + qVal;
            end
         end
      endcase
   end

   // Addressing state; unlisten and untalk end the session
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         listenEn_r <= 1'b0;
         talkEn_r <= 1'b0;
         cmdListen_r <= 1'b0;
         lastAddrd_r <= 1'b0;
         lastTalk_r <= 1'b0;
         selOp_r <= OP_NONE;
         started_r <= 1'b0;
      end else begin
         if (isListen && addr == ADDR_NONE) begin
            listenEn_r <= 1'b0;
         end else if (isListen && ourListen) begin
            listenEn_r <= 1'b1;
            cmdListen_r <= altMode && addr == commandPrimaryAddress;
            selOp_r <= altMode ? pendOp_r : OP_PRINT;
            started_r <= 1'b0;
         end
         if (isTalk && ourTalk) begin
            talkEn_r <= 1'b1;
            selOp_r <= altMode ? pendOp_r : OP_INPUT;
            started_r <= 1'b0;
         end else if (isTalk) begin
            talkEn_r <= 1'b0; // Untalk or another talker
         end
         if (byteValid && atnIn) begin
            lastAddrd_r <= (isListen || isTalk) && ourListen;
            lastTalk_r <= isTalk;
         end
         if (isSecond && lastAddrd_r && !altMode) begin
            selOp_r <= secOp;
         end
         if (talkStart || listenStart) begin
            started_r <= 1'b1;
         end
      end
   end

   // Letter channel and argument fields
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         letterSeen_r <= 1'b0;
         letOp_r <= OP_NONE;
         pendOp_r <= OP_NONE;
         fldIdx_r <= 2'h0;
         fldDig_r <= 1'b0;
         for (int i = 0; i < 4; i++) begin
            fld_r[i] <= 16'h0000;
         end
      end else begin
         if (isListen && ourListen) begin
            letterSeen_r <= 1'b0;
            fldIdx_r <= 2'h0;
            fldDig_r <= 1'b0;
            for (int i = 0; i < 4; i++) begin
               fld_r[i] <= 16'h0000;
            end
         end else if (dataByte && cmdListen_r && !letterSeen_r) begin
            letterSeen_r <= 1'b1;
            letOp_r <= letter_to_op(byteData);
         end else if (dataByte && !is_rec(selOp_r)) begin
            if (digitSeen) begin
               fld_r[fldIdx_r] <= 16'(fld_r[fldIdx_r] * 16'd10 + {8'h00, byteData - CHAR_ZERO});
               fldDig_r <= 1'b1;
            end else if (sepSeen && fldDig_r && fldIdx_r != 2'h3) begin
               fldIdx_r <= fldIdx_r + 2'h1; // Leading separators are skipped
               fldDig_r <= 1'b0;
            end
         end
         // Non-immediate letters wait for the next talk or data listen session
         if (argFinish && cmdListen_r && !is_arg(letOp_r)) begin
            pendOp_r <= letOp_r;
         end else if (talkStart || listenStart) begin
            pendOp_r <= OP_NONE;
         end
      end
   end

   // Commands to the engine and the status parameters
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cmdValid <= 1'b0;
         cmd <= '0;
         statusBits <= 4'h0;
         rereadClr <= 1'b0;
      end else begin
         cmdValid <= 1'b0;
         rereadClr <= talkStart && selOp_r == OP_RDERRQ;
         if (argFinish && is_arg(argOp)) begin
            cmdValid <= 1'b1;
            cmd <= '{op: argOp, arg0: fld_r[0], arg1: fld_r[1]};
            if (argOp == OP_SETSTAT) begin
               for (int i = 0; i < 4; i++) begin
                  statusBits[i] <= fld_r[i] != 16'h0000;
               end
            end
         end else if ((listenStart && is_rec(selOp_r)) ||
               (talkStart && selOp_r != OP_NONE && !is_query(selOp_r))) begin
            cmdValid <= 1'b1;
            cmd <= '{op: selOp_r, arg0: 16'h0000, arg1: 16'h0000};
         end
      end
   end

   // Recorded bytes pass straight to the engine
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         recording_r <= 1'b0;
         wrValid <= 1'b0;
         wrData <= 8'h00;
         wrLast <= 1'b0;
         dataEnd <= 1'b0;
      end else begin
         wrValid <= dataByte && recording_r;
         wrData <= byteData;
         wrLast <= eoiIn && selOp_r == OP_WRITE;
         dataEnd <= isListen && addr == ADDR_NONE && recording_r;
         if (listenStart && is_rec(selOp_r)) begin
            recording_r <= 1'b1;
         end else if (isListen && (addr == ADDR_NONE || ourListen)) begin
            recording_r <= 1'b0;
         end
      end
   end

   // Talk path: query image or engine stream, one byte held at a time
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         streaming_r <= 1'b0;
         qIdx_r <= 4'h0;
         qLen_r <= 4'h0;
         txValid <= 1'b0;
         tx <= '0;
         srcTake <= 1'b0;
         for (int i = 0; i < 8; i++) begin
            qBuf_r[i] <= 8'h00;
         end
      end else begin
         srcTake <= 1'b0;
         if (txAccept) begin
            txValid <= 1'b0;
         end
         if (!talkEn_r) begin
            streaming_r <= 1'b0; // Untalk drops any held byte
            qIdx_r <= qLen_r;
            txValid <= 1'b0;
         end else if (talkStart && is_query(selOp_r)) begin
            qBuf_r <= qImg;
            qLen_r <= qLen;
            qIdx_r <= 4'h0;
         end else if (talkStart && selOp_r != OP_NONE) begin
            streaming_r <= 1'b1;
         end else if (txFree && qIdx_r != qLen_r) begin
            txValid <= 1'b1;
            tx <= '{data: qBuf_r[qIdx_r[2:0]], eoi: 1'b0};
            qIdx_r <= qIdx_r + 4'h1;
         end else if (txFree && streaming_r && srcValid && !srcTake) begin
            txValid <= 1'b1;
            tx <= '{data: srcData, eoi: srcLast && selOp_r == OP_TALK};
            srcTake <= 1'b1;
            streaming_r <= !srcLast;
         end
      end
   end

   // Error flag: a new error wins over the clear by the error query
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         errFlag <= 1'b0;
      end else if (errSet) begin
         errFlag <= 1'b1;
      end else if (errClr) begin
         errFlag <= 1'b0;
      end
   end

   // Addressed state shown to the bus interface
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         talkActive <= 1'b0;
         listenActive <= 1'b0;
      end else begin
         talkActive <= talkEn_r;
         listenActive <= listenEn_r;
      end
   end
endmodule : gpib_tape_command_decoder
`default_nettype wire

// ===== tb/gpib_tape_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module gpib_tape_monitor
   import gpib_tape_pkg::*;
(
   input wire logic ref_clk, // Clock
   input wire logic arst_n, // Async reset
   input wire logic byteValid, // Bus byte strobe
   input wire logic [7:0] byteData, // Bus byte
   input wire logic atnIn, // ATN level
   input wire logic eoiIn, // EOI with byte
   input wire logic [4:0] addrSwitch, // Address switches
   input wire logic altMode, // Alternate protocol
   input wire logic txAccept, // Talk byte taken
   input wire logic engErr, // Engine error pulse
   input wire cmd_s cmd, // Command out
   input wire logic cmdValid, // Command strobe
   input wire logic wrValid, // Record strobe
   input wire logic wrLast, // Record EOI
   input wire logic dataEnd, // Recording closed
   input wire logic srcTake, // Engine byte used
   input wire talk_s tx, // Talk byte
   input wire logic txValid, // Talk byte valid
   input wire logic errFlag, // Error pending
   input wire logic talkActive, // Talker state
   input wire logic listenActive // Listener state
);
   // One clock domain, so one clocking and one reset guard for all
   default clocking mc @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n);

   AST_ARG_AFTER_CR: assert property (cmdValid && cmd.op inside {OP_FIND, OP_KILL, OP_MARK,
      OP_CLOSE, OP_SECRET, OP_SETSTAT} |-> $past(byteValid && !atnIn && byteData == CHAR_CR))
      else $error("argument command without a carriage return before it");
   AST_LISTEN_ADDR: assert property (byteValid && atnIn && !altMode
      && byteData[6:0] == {GRP_LISTEN, addrSwitch} |=> ##1 listenActive)
      else $error("own listen address not taken");
   AST_TALK_ADDR: assert property (byteValid && atnIn && !altMode
      && byteData[6:0] == {GRP_TALK, addrSwitch} |=> ##1 talkActive)
      else $error("own talk address not taken");
   AST_UNLISTEN: assert property (byteValid && atnIn
      && byteData[6:0] == {GRP_LISTEN, ADDR_NONE} |=> ##1 !listenActive)
      else $error("still listening after unlisten");
   AST_TX_HOLD: assert property (txValid && !txAccept |=> txValid && $stable(tx))
      else $error("talk byte changed before it was taken");
   AST_REC_SRC: assert property (wrValid |-> $past(byteValid && !atnIn))
      else $error("record byte without a data byte");
   AST_WRLAST: assert property (wrLast |-> wrValid && $past(eoiIn))
      else $error("last record flag without EOI");
   AST_END_CAUSE: assert property (dataEnd
      |-> $past(byteValid && atnIn && byteData[6:0] == {GRP_LISTEN, ADDR_NONE}))
      else $error("recording closed without unlisten");
   AST_ALT_SEC: assert property (altMode && byteValid && atnIn && byteData[6:5] == GRP_SECOND
      && !errFlag && !engErr |=> !errFlag)
      else $error("secondary address refused in alternate mode");
   AST_TAKE_TALK: assert property (srcTake |-> talkActive)
      else $error("stream byte taken while not talker");
endmodule : gpib_tape_monitor

bind gpib_tape_command_decoder gpib_tape_monitor mon (.ref_clk(ref_clk), .arst_n(arst_n),
   .byteValid(byteValid), .byteData(byteData), .atnIn(atnIn), .eoiIn(eoiIn),
   .addrSwitch(addrSwitch), .altMode(altMode), .txAccept(txAccept), .engErr(engErr),
   .cmd(cmd), .cmdValid(cmdValid), .wrValid(wrValid), .wrLast(wrLast), .dataEnd(dataEnd),
   .srcTake(srcTake), .tx(tx), .txValid(txValid), .errFlag(errFlag),
   .talkActive(talkActive), .listenActive(listenActive));
`default_nettype wire

// ===== tb/gpib_controller_model.sv
`timescale 1ns/1ps
`default_nettype none
module gpib_controller_model
   import gpib_tape_pkg::*;
(
   input wire logic ref_clk, // Clock
   input wire talk_s tx, // Byte from the drive
   input wire logic txValid, // Drive byte valid
   output logic txAccept, // Byte taken
   output logic byteValid, // Bus byte strobe
   output logic [7:0] byteData, // Bus byte
   output logic atnIn, // ATN level
   output logic eoiIn // EOI with byte
);
   logic [7:0] rxQ [$];
   logic rxEoi [$];
   int lag = 0;
   int waitCnt = 0;

   initial begin
      txAccept = 1'b0;
      byteValid = 1'b0;
      byteData = 8'h00;
      atnIn = 1'b0;
      eoiIn = 1'b0;
   end

   // One byte per call with a gap after it, so the strobe never toggles twice in a step
   task automatic send(input logic [7:0] b, input logic atn, input logic eoi);
      @(negedge ref_clk);
      byteValid = 1'b1;
      byteData = b;
      atnIn = atn;
      eoiIn = eoi;
      @(negedge ref_clk);
      byteValid = 1'b0;
      byteData = ~b; // Released lines must not keep the old value
      eoiIn = 1'b0;
   endtask : send

   // Drop ATN without a byte so the addressed drive starts talking
   task automatic release_atn;
      @(negedge ref_clk);
      atnIn = 1'b0;
   endtask : release_atn

   // Acceptor: a lag of stall cycles shows whether the talker really holds its byte
   always @(negedge ref_clk) begin
      if (txAccept) begin
         txAccept = 1'b0;
      end else if (txValid === 1'b1) begin
         if (waitCnt < lag) begin
            waitCnt++;
         end else begin
            waitCnt = 0;
            rxQ.push_back(tx.data);
            rxEoi.push_back(tx.eoi);
            txAccept = 1'b1;
         end
      end
   end
endmodule : gpib_controller_model
`default_nettype wire

// ===== tb/test_gpib_tape_command_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
   $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module test_gpib_tape_command_decoder;
   import gpib_tape_pkg::*;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic byteValid, atnIn, eoiIn, txAccept, srcValid, srcLast;
   logic [7:0] byteData, srcData, wrData;
   logic [4:0] addrSwitch = 5'h02;
   logic altMode = 1'b0;
   logic [3:0] errCode = 4'h0;
   logic [7:0] rereadCount = 8'h00;
   logic [2:0] typeDigit = 3'h0;
   cmd_s cmd;
   talk_s tx;
   logic cmdValid, wrValid, wrLast, dataEnd, srcTake, txValid, rereadClr, errFlag;
   logic talkActive, listenActive;
   logic [3:0] statusBits;
   logic [7:0] srcBuf [4] = '{8'h11, 8'h22, 8'h33, 8'h00};
   logic [8:0] wrQ [$];
   logic sawEnd = 1'b0;
   logic sawClr = 1'b0;
   int srcIdx = 0;
   int srcLen = 0;
   int cmdCount = 0;
   int bad_count = 0;
   int n_tests = 0;
   int c0;
   int i;

   always #2.5 ref_clk = ~ref_clk;

   // Tape engine stream: advances one byte per take
   assign srcValid = srcIdx < srcLen;
   assign srcData = srcBuf[srcIdx];
   assign srcLast = srcIdx == srcLen - 1;

   // Sticky record of pulses, sampled where they are settled
   always @(negedge ref_clk) begin
      if (srcTake === 1'b1) srcIdx++;
      if (wrValid === 1'b1) wrQ.push_back({wrLast, wrData});
      if (dataEnd === 1'b1) sawEnd = 1'b1;
      if (rereadClr === 1'b1) sawClr = 1'b1;
      if (cmdValid === 1'b1) cmdCount++;
   end

   gpib_tape_command_decoder uut (.ref_clk(ref_clk), .arst_n(arst_n), .byteValid(byteValid),
      .byteData(byteData), .atnIn(atnIn), .eoiIn(eoiIn), .addrSwitch(addrSwitch),
      .altMode(altMode), .txAccept(txAccept), .srcValid(srcValid), .srcData(srcData),
      .srcLast(srcLast), .errCode(errCode), .engErr(1'b0), .rereadCount(rereadCount),
      .typeDigit(typeDigit), .cmd(cmd), .cmdValid(cmdValid), .wrValid(wrValid),
      .wrData(wrData), .wrLast(wrLast), .dataEnd(dataEnd), .srcTake(srcTake), .tx(tx),
      .txValid(txValid), .rereadClr(rereadClr), .errFlag(errFlag), .statusBits(statusBits),
      .talkActive(talkActive), .listenActive(listenActive));

   gpib_controller_model ctl (.ref_clk(ref_clk), .tx(tx), .txValid(txValid),
      .txAccept(txAccept), .byteValid(byteValid), .byteData(byteData), .atnIn(atnIn),
      .eoiIn(eoiIn));

   task automatic complete_run;
      $display("Checks %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : complete_run

   task automatic give_up;
      bad_count++;
      $display("[ERR] %0t wait ran out", $time);
      complete_run();
   endtask : give_up

   // Address, secondary, then characters and carriage return with ATN off
   task automatic say(input logic [7:0] addr, input logic [7:0] sa, input string s);
      ctl.send(addr, 1'b1, 1'b0);
      ctl.send(sa, 1'b1, 1'b0);
      for (int k = 0; k < s.len(); k++) ctl.send(s[k], 1'b0, 1'b0);
      ctl.send(CHAR_CR, 1'b0, 1'b0);
   endtask : say

   task automatic expect_cmd(input op_e op);
      int k;
      for (k = 0; k < 50 && cmdValid !== 1'b1; k++) @(negedge ref_clk);
      if (k == 50) give_up();
      `CHK(cmd.op, op)
   endtask : expect_cmd

   task automatic arg_cmd(input logic [7:0] addr, input logic [7:0] sa, input string s,
      input op_e op, input logic [15:0] a0, input logic [15:0] a1);
      say(addr, sa, s);
      expect_cmd(op);
      `CHK(cmd.arg0, a0)
      `CHK(cmd.arg1, a1)
      ctl.send(8'h3f, 1'b1, 1'b0);
   endtask : arg_cmd

   // Talk query: every byte up to and including the terminator is compared
   task automatic talk_q(input logic [7:0] addr, input logic [7:0] sa, input string s);
      int k;
      ctl.rxQ.delete();
      ctl.send(addr, 1'b1, 1'b0);
      ctl.send(sa, 1'b1, 1'b0);
      ctl.release_atn();
      for (k = 0; k < 300 && ctl.rxQ.size() < s.len(); k++) @(negedge ref_clk);
      if (k == 300) give_up();
      for (k = 0; k < s.len(); k++) `CHK(ctl.rxQ[k], s[k])
      ctl.send(8'h5f, 1'b1, 1'b0);
   endtask : talk_q

   initial begin
      repeat (20) @(negedge ref_clk);
      arst_n = 1'b1;
      repeat (2) @(negedge ref_clk);
      arg_cmd(8'h22, 8'h62, "", OP_CLOSE, 16'h0000, 16'h0000);
      arg_cmd(8'h22, 8'h7b, "5", OP_FIND, 16'h0005, 16'h0000);
      arg_cmd(8'h22, 8'h67, "9", OP_KILL, 16'h0009, 16'h0000);
      arg_cmd(8'h22, 8'h7c, "1,2000", OP_MARK, 16'h0001, 16'h07d0);
      arg_cmd(8'h22, 8'h7d, "", OP_SECRET, 16'h0000, 16'h0000);
      arg_cmd(8'h22, 8'h60, "1,0,1,1", OP_SETSTAT, 16'h0001, 16'h0000);
      `CHK(statusBits, 4'hd)
      talk_q(8'h42, 8'h60, "1,0,1,1\015");
      typeDigit = 3'h3;
      talk_q(8'h42, 8'h66, "3\015");
      rereadCount = 8'h0c;
      talk_q(8'h42, 8'h78, "12\015");
      `CHK(sawClr, 1'b1)
      // Unknown secondary: flagged, no command reaches the engine
      c0 = cmdCount;
      ctl.send(8'h22, 1'b1, 1'b0);
      ctl.send(8'h65, 1'b1, 1'b0);
      ctl.send(CHAR_CR, 1'b0, 1'b0);
      `CHK(errFlag, 1'b1)
      `CHK({talkActive, listenActive}, 2'b01)
      ctl.send(8'h3f, 1'b1, 1'b0);
      `CHK(cmdCount, c0)
      talk_q(8'h42, 8'h7e, "1\015");
      `CHK(errFlag, 1'b0)
      // Binary record closed by unlisten, last byte marked with EOI
      ctl.send(8'h22, 1'b1, 1'b0);
      ctl.send(8'h6f, 1'b1, 1'b0);
      ctl.release_atn();
      expect_cmd(OP_WRITE);
      ctl.send(8'ha5, 1'b0, 1'b0);
      ctl.send(8'h5a, 1'b0, 1'b0);
      ctl.send(8'hff, 1'b0, 1'b1);
      ctl.send(8'h3f, 1'b1, 1'b0);
      @(negedge ref_clk);
      `CHK(wrQ.size(), 3)
      `CHK(wrQ[0], 9'h0a5)
      `CHK(wrQ[2], 9'h1ff)
      `CHK(sawEnd, 1'b1)
      // Stream to a slow listener, end flagged with EOI
      srcLen = 3;
      ctl.lag = 2;
      ctl.rxQ.delete();
      ctl.rxEoi.delete();
      ctl.send(8'h42, 1'b1, 1'b0);
      ctl.send(8'h7a, 1'b1, 1'b0);
      ctl.release_atn();
      for (i = 0; i < 300 && ctl.rxQ.size() < 3; i++) @(negedge ref_clk);
      if (i == 300) give_up();
      `CHK(ctl.rxQ[2], 8'h33)
      `CHK(ctl.rxEoi[1], 1'b0)
      `CHK(ctl.rxEoi[2], 1'b1)
      ctl.send(8'h5f, 1'b1, 1'b0);
      ctl.lag = 0;
      // Alternate protocol: command address 3, data address 2
      altMode = 1'b1;
      errCode = 4'h7;
      arg_cmd(8'h23, 8'h7b, "F,5", OP_FIND, 16'h0005, 16'h0000);
      // Secondary 5 is refused in the base protocol, ignored here
      say(8'h23, 8'h65, "E");
      ctl.send(8'h3f, 1'b1, 1'b0);
      talk_q(8'h42, 8'h65, "7\015");
      srcIdx = 0;
      say(8'h23, 8'h65, "I");
      ctl.send(8'h3f, 1'b1, 1'b0);
      talk_q(8'h42, 8'h65, "\021\0423");
      srcIdx = 0;
      say(8'h23, 8'h65, "H");
      ctl.send(8'h3f, 1'b1, 1'b0);
      talk_q(8'h43, 8'h65, "\021\0423");
      complete_run();
   end
endmodule : test_gpib_tape_command_decoder
`undef CHK
`default_nettype wire
